// ==== design/udsr_regs.svh ====
`ifndef UDSR_REGS_SVH
`define UDSR_REGS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define UDSR_CMD_DEV_STATUS 8'hFE
`define UDSR_CMD_FAULT_CODE 8'hFF

// ----------------------------------------
// Status and fault byte fields
// ----------------------------------------
`define UDSR_ST_ATTACH 0
`define UDSR_ST_ATTACH_CH 1
`define UDSR_ST_LOW_POWER 2
`define UDSR_ST_LOW_POWER_CH 3
`define UDSR_ST_BUS_RESET 4
`define UDSR_FC_PENDING 4
`define UDSR_STATUS_RESET 8'h00
`define UDSR_FAULT_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define UDSR_CLK_HZ 40000000
`define UDSR_IDLE_US 3000
`define UDSR_IDLE_CYCLES ((`UDSR_CLK_HZ / 1000000) * `UDSR_IDLE_US)

`endif

// ==== design/udsr_pkg.sv ====
package udsr_pkg;
	typedef enum logic [3:0] {
		UDSR_FC_NONE = 4'h0,
		UDSR_FC_PID_ENC = 4'h1,
		UDSR_FC_PID_UNKNOWN = 4'h2,
		UDSR_FC_UNEXP_PKT = 4'h3,
		UDSR_FC_TOKEN_CRC = 4'h4,
		UDSR_FC_DATA_CRC = 4'h5,
		UDSR_FC_TIMEOUT = 4'h6,
		UDSR_FC_BABBLE = 4'h7,
		UDSR_FC_EOP = 4'h8,
		UDSR_FC_NAK = 4'h9,
		UDSR_FC_STALL = 4'hA,
		UDSR_FC_OVERRUN = 4'hB,
		UDSR_FC_ISO_EMPTY = 4'hC,
		UDSR_FC_BITSTUFF = 4'hD,
		UDSR_FC_SYNC = 4'hE,
		UDSR_FC_TOGGLE = 4'hF
	} udsr_fault_t;
endpackage

// ==== design/udsr_sync.sv ====
`timescale 1ns/10ps
// Three-stage synchroniser; output changes once stages two and three agree.
module udsr_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic d,
	output logic q
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= 1'b0;
		end else if (s2_r == s3_r) begin
			q <= s3_r;
		end
	end
endmodule

// ==== design/udsr_idle.sv ====
`timescale 1ns/10ps
// Counts cycles without bus activity; flags idle once the limit is passed.
module udsr_idle #(
	parameter int IDLE_CYCLES = 120000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Activity in, idle out
	input wire logic activity,
	output logic idle
);
	logic [31:0] cnt_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 32'h0;
			idle <= 1'b0;
		end else if (activity) begin
			cnt_r <= 32'h0;
			idle <= 1'b0;
		end else if (cnt_r >= 32'(IDLE_CYCLES)) begin
			idle <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end
endmodule

// ==== design/udsr_top.sv ====
`timescale 1ns/10ps
`include "udsr_regs.svh"

module udsr_top
	import udsr_pkg::*;
#(
	parameter int IDLE_CYCLES = `UDSR_IDLE_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command interface
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] wr_data,
	input wire logic cmd_write,
	output logic rd_valid,
	output logic [7:0] rd_data,
	// Link events
	input wire logic bus_activity,
	input wire logic bus_reset_pin,
	input wire logic vbus_lost,
	input wire logic fault_valid,
	input wire logic [3:0] fault_in,
	// Status outputs
	output logic attach_pin_n,
	output logic status_change_irq,
	output logic dev_unconfigured,
	output logic addr_zero_only,
	output logic ctrl_ep_stall,
	output logic ep_unrealize,
	output logic buffers_flush,
	output logic toggles_reset
);
	// ----------------------------------------
	// Input conditioning
	// ----------------------------------------
	logic act_s;
	logic rst_s;
	logic rst_d_r;
	logic idle;
	logic bus_reset_ev;

	udsr_sync u_sync_act (
		.clk(clk),
		.rst(rst),
		.d(bus_activity),
		.q(act_s)
	);

	udsr_sync u_sync_rst (
		.clk(clk),
		.rst(rst),
		.d(bus_reset_pin),
		.q(rst_s)
	);

	udsr_idle #(
		.IDLE_CYCLES(IDLE_CYCLES)
	) u_idle (
		.clk(clk),
		.rst(rst),
		.activity(act_s),
		.idle(idle)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_d_r <= 1'b0;
		end else begin
			rst_d_r <= rst_s;
		end
	end

	// ----------------------------------------
	// Device status byte
	// ----------------------------------------
	logic attach_r;
	logic attach_ch_r;
	logic low_power_state_flag;
	logic low_power_state_changed;
	logic bus_reset_r;
	logic rd_status;
	logic rd_fault;
	logic wr_status;
	logic lp_nxt;
	logic lp_ch_ev;
	logic attach_nxt;

	assign rd_status = cmd_valid && !cmd_write && cmd_code == `UDSR_CMD_DEV_STATUS;
	assign rd_fault = cmd_valid && !cmd_write && cmd_code == `UDSR_CMD_FAULT_CODE;
	assign wr_status = cmd_valid && cmd_write && cmd_code == `UDSR_CMD_DEV_STATUS;
	assign bus_reset_ev = rst_s && !rst_d_r && attach_r;
	// Loss of bus power wins over a write only while attached; pin and flag both load attach_nxt, so never disagree.
	assign attach_nxt = (vbus_lost && attach_r) ? 1'b0 :
		(wr_status ? wr_data[`UDSR_ST_ATTACH] : attach_r);
	// Detach forces the low-power flag on, as a detached port is idle.
	assign lp_nxt = idle || !attach_r;
	assign lp_ch_ev = lp_nxt != low_power_state_flag;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			attach_r <= 1'b0;
			attach_ch_r <= 1'b0;
		end else begin
			attach_r <= attach_nxt;
			if (vbus_lost && attach_r) begin
				attach_ch_r <= 1'b1;
			end else if (rd_status) begin
				attach_ch_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_power_state_flag <= 1'b0;
			low_power_state_changed <= 1'b0;
		end else begin
			low_power_state_flag <= lp_nxt;
			if (lp_ch_ev) begin
				low_power_state_changed <= 1'b1;
			end else if (rd_status) begin
				low_power_state_changed <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_reset_r <= 1'b0;
		end else if (bus_reset_ev) begin
			bus_reset_r <= 1'b1;
		end else if (rd_status) begin
			bus_reset_r <= 1'b0;
		end
	end

	// Event pulse registered together with the flag that it reports.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_change_irq <= 1'b0;
		end else begin
			status_change_irq <= lp_ch_ev || bus_reset_ev || (vbus_lost && attach_r);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			attach_pin_n <= 1'b1;
		end else begin
			attach_pin_n <= !attach_nxt;
		end
	end

	// ----------------------------------------
	// Default-state actions on bus reset
	// ----------------------------------------
	// Endpoint interrupt status is left untouched by this block.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dev_unconfigured <= 1'b1;
			addr_zero_only <= 1'b1;
			ctrl_ep_stall <= 1'b0;
			ep_unrealize <= 1'b0;
			buffers_flush <= 1'b0;
			toggles_reset <= 1'b0;
		end else begin
			if (bus_reset_ev) begin
				dev_unconfigured <= 1'b1;
				addr_zero_only <= 1'b1;
			end else if (wr_status) begin
				dev_unconfigured <= 1'b0;
				addr_zero_only <= 1'b0;
			end
			ctrl_ep_stall <= bus_reset_ev;
			ep_unrealize <= bus_reset_ev;
			buffers_flush <= bus_reset_ev;
			toggles_reset <= bus_reset_ev;
		end
	end

	// ----------------------------------------
	// Fault code byte
	// ----------------------------------------
	udsr_fault_t fault_r;
	logic fault_pending;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_r <= UDSR_FC_NONE;
			fault_pending <= 1'b0;
		end else begin
			if (fault_valid) begin
				fault_r <= udsr_fault_t'(fault_in);
			end
			if (fault_valid && fault_in != 4'h0) begin
				fault_pending <= 1'b1;
			end else if (rd_fault) begin
				fault_pending <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read answers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			rd_valid <= rd_status || rd_fault;
			if (rd_status) begin
				rd_data <= {3'h0, bus_reset_r, low_power_state_changed,
					low_power_state_flag, attach_ch_r, attach_r};
			end else if (rd_fault) begin
				rd_data <= {3'h0, fault_pending, 4'(fault_r)};
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_reset_edge;
		rst_s && !rst_d_r && attach_r;
	endsequence

	AST_IRQ_ON_LPCH: assert property (@(posedge clk) disable iff (rst)
		lp_ch_ev |=> status_change_irq && low_power_state_changed)
		else $error("low-power change without interrupt");
	AST_RST_FLAG: assert property (@(posedge clk) disable iff (rst)
		s_reset_edge |=> bus_reset_r && status_change_irq)
		else $error("bus reset not flagged");
	AST_DEFAULT: assert property (@(posedge clk) disable iff (rst)
		s_reset_edge |=> dev_unconfigured && addr_zero_only)
		else $error("default state not entered");
	AST_STALL: assert property (@(posedge clk) disable iff (rst)
		s_reset_edge |=> ctrl_ep_stall ##1 !ctrl_ep_stall || bus_reset_ev)
		else $error("control endpoint not stalled");
	AST_FLUSH: assert property (@(posedge clk) disable iff (rst)
		s_reset_edge |=> ep_unrealize && buffers_flush && toggles_reset)
		else $error("endpoints not reset");
	AST_IGNORE: assert property (@(posedge clk) disable iff (rst)
		!attach_r && !bus_reset_r |=> !bus_reset_r)
		else $error("bus reset taken while detached");
	AST_STATUS_RD: assert property (@(posedge clk) disable iff (rst)
		rd_status && !bus_reset_ev |=> rd_valid && rd_data[`UDSR_ST_BUS_RESET] == $past(bus_reset_r)
			&& rd_data[7:5] == 3'h0)
		else $error("status read wrong");
	AST_FAULT_RD: assert property (@(posedge clk) disable iff (rst)
		rd_fault |=> rd_valid && rd_data[3:0] == $past(4'(fault_r))
			&& rd_data[`UDSR_FC_PENDING] == $past(fault_pending))
		else $error("fault code read wrong");
	AST_PEND_CLR: assert property (@(posedge clk) disable iff (rst)
		rd_fault && !(fault_valid && fault_in != 4'h0) |=> !fault_pending)
		else $error("pending flag not cleared");
	AST_PEND_SET: assert property (@(posedge clk) disable iff (rst)
		fault_valid && fault_in != 4'h0 |=> fault_pending)
		else $error("pending flag not set");
	AST_IDLE: assert property (@(posedge clk) disable iff (rst)
		act_s && attach_r ##1 attach_r |=> !low_power_state_flag)
		else $error("low-power flag not cleared by activity");
	AST_ATTACH_PIN: assert property (@(posedge clk) disable iff (rst)
		attach_pin_n == !attach_r)
		else $error("attach pin disagrees with attach flag");
	AST_LP_CLR: assert property (@(posedge clk) disable iff (rst)
		rd_status && !lp_ch_ev |=> !low_power_state_changed)
		else $error("low-power change not cleared by read");
	AST_IGNORE_PULSE: assert property (@(posedge clk) disable iff (rst)
		rst_s && !rst_d_r && !attach_r |=> !ctrl_ep_stall && !toggles_reset)
		else $error("default-state actions while detached");
	AST_RD_ONE: assert property (@(posedge clk) disable iff (rst)
		!rd_status && !rd_fault |=> !rd_valid)
		else $error("read answer without read command");
	AST_FAULT_CAP: assert property (@(posedge clk) disable iff (rst)
		fault_valid |=> 4'(fault_r) == $past(fault_in))
		else $error("fault code not captured");
endmodule

// ==== verif/udsr_host_model.sv ====
`timescale 1ns/10ps
// Upstream host: stops bus traffic on request and drives a shortened bus reset burst.
module udsr_host_model (
	input wire logic clk,
	input wire logic quiet,
	input wire logic reset_req,
	output logic bus_activity,
	output logic bus_reset_pin
);
	logic [3:0] burst_r = 4'h0;
	always @(posedge clk) begin
		if (reset_req)
			burst_r <= 4'h8;
		else if (burst_r != 4'h0)
			burst_r <= burst_r - 4'h1;
	end
	assign bus_reset_pin = (burst_r != 4'h0);
	assign bus_activity = !quiet;
endmodule

// ==== verif/udsr_top_tb.sv ====
`timescale 1ns/10ps
module udsr_top_tb;
	import udsr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [7:0] cmd_code = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic cmd_write = 1'b0;
	logic vbus_lost = 1'b0;
	logic fault_valid = 1'b0;
	logic [3:0] fault_in = 4'h0;
	logic quiet = 1'b0;
	logic reset_req = 1'b0;
	logic rd_valid, attach_pin_n, status_change_irq, dev_unconfigured, addr_zero_only;
	logic ctrl_ep_stall, ep_unrealize, buffers_flush, toggles_reset, bus_activity, bus_reset_pin;
	logic [7:0] rd_data;
	logic [15:0] exp_q[$];
	logic [15:0] note;
	logic [3:0] v;
	int error_cnt = 0;
	int n_compared = 0;
	int seed = 41;
	int hits;
	int pulse_cnt = 0;

	always #12.5 clk = ~clk;

	udsr_top #(.IDLE_CYCLES(50)) u_udsr_top (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .wr_data(wr_data), .cmd_write(cmd_write), .rd_valid(rd_valid),
		.rd_data(rd_data), .bus_activity(bus_activity), .bus_reset_pin(bus_reset_pin),
		.vbus_lost(vbus_lost), .fault_valid(fault_valid), .fault_in(fault_in),
		.attach_pin_n(attach_pin_n), .status_change_irq(status_change_irq),
		.dev_unconfigured(dev_unconfigured), .addr_zero_only(addr_zero_only),
		.ctrl_ep_stall(ctrl_ep_stall), .ep_unrealize(ep_unrealize),
		.buffers_flush(buffers_flush), .toggles_reset(toggles_reset));
	udsr_host_model u_udsr_host_model (.clk(clk), .quiet(quiet), .reset_req(reset_req),
		.bus_activity(bus_activity), .bus_reset_pin(bus_reset_pin));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("errors=%0d compared=%0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Issues one command; a nonzero mask in the note queues {mask, expected byte}.
	task automatic cmd(input logic [7:0] code, input logic wr, input logic [7:0] d,
		input logic [15:0] nt);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_write <= wr;
		wr_data <= d;
		if (nt[15:8] != 8'h00)
			exp_q.push_back(nt);
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask

	// Counts the falling edges, out of n, at which status_change_irq is high; the pulse needs no clearing.
	task automatic wait_irq(input int n, output int got);
		got = 0;
		repeat (n) begin
			@(negedge clk);
			if (status_change_irq === 1'b1)
				got++;
		end
	endtask

	always @(negedge clk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(8'h01, 8'h00);
			end else begin
				note = exp_q.pop_front();
				chk(rd_data & note[15:8], note[7:0]);
			end
		end
		if (ctrl_ep_stall === 1'b1) begin
			pulse_cnt++;
			chk({4'h0, status_change_irq, ep_unrealize, buffers_flush, toggles_reset}, 8'h0F);
		end
	end

	initial begin
		#(25 * 8000);
		error_cnt++;
		print_verdict();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		cmd(8'hFE, 1'b1, 8'h01, 16'h0000);
		@(negedge clk);
		chk({5'h00, attach_pin_n, dev_unconfigured, addr_zero_only}, 8'h00);
		cmd(8'hFE, 1'b0, 8'h00, 16'hF501);
		cmd(8'hFE, 1'b0, 8'h00, 16'hFF01);
		quiet <= 1'b1;
		wait_irq(120, hits);
		chk(hits[7:0], 8'h01);
		cmd(8'hFE, 1'b0, 8'h00, 16'hFF0D);
		cmd(8'hFE, 1'b0, 8'h00, 16'hFF05);
		quiet <= 1'b0;
		wait_irq(20, hits);
		chk(hits[7:0], 8'h01);
		cmd(8'hFE, 1'b0, 8'h00, 16'hFF09);
		cmd(8'hFE, 1'b0, 8'h00, 16'hFF01);
		@(posedge clk);
		reset_req <= 1'b1;
		@(posedge clk);
		reset_req <= 1'b0;
		wait_irq(20, hits);
		chk(hits[7:0], 8'h01);
		chk(pulse_cnt[7:0], 8'h01);
		chk({6'h00, dev_unconfigured, addr_zero_only}, 8'h03);
		cmd(8'hFE, 1'b0, 8'h00, 16'hFF11);
		cmd(8'hFE, 1'b0, 8'h00, 16'hFF01);
		cmd(8'hFE, 1'b1, 8'h01, 16'h0000);
		vbus_lost <= 1'b1;
		wait_irq(20, hits);
		chk({7'h00, hits > 0}, 8'h01);
		chk({7'h00, attach_pin_n}, 8'h01);
		cmd(8'hFE, 1'b0, 8'h00, 16'hFF0E);
		cmd(8'hFE, 1'b0, 8'h00, 16'hFF04);
		reset_req <= 1'b1;
		@(posedge clk);
		reset_req <= 1'b0;
		wait_irq(20, hits);
		chk(hits[7:0], 8'h00);
		chk({pulse_cnt[6:0], dev_unconfigured}, 8'h02);
		for (int i = 0; i < 20; i++) begin
			v = (i < 16) ? i[3:0] : 4'($random(seed));
			@(posedge clk);
			fault_valid <= 1'b1;
			fault_in <= v;
			@(posedge clk);
			fault_valid <= 1'b0;
			cmd(8'hFF, 1'b0, 8'h00, {8'hFF, 3'h0, v != 4'h0, v});
			cmd(8'hFF, 1'b0, 8'h00, {8'hFF, 4'h0, v});
		end
		cmd(8'hFD, 1'b0, 8'h00, 16'h0000);
		cmd(8'hFF, 1'b1, 8'hFF, 16'h0000);
		cmd(8'hFF, 1'b0, 8'h00, {8'hFF, 4'h0, v});
		repeat (4) @(posedge clk);
		chk({7'h00, exp_q.size() == 0}, 8'h01);
		print_verdict();
	end
endmodule
